// file: rsdir_consts.svh
// Constants for the RS-232/RS-485 direction switch
`ifndef RSDIR_CONSTS_SVH
`define RSDIR_CONSTS_SVH
`define RSDIR_CLK_HZ        125000000
`define RSDIR_TA_1MS_CYC    ((`RSDIR_CLK_HZ / 1000) * 1)
`define RSDIR_TA_2MS_CYC    ((`RSDIR_CLK_HZ / 1000) * 2)
`define RSDIR_TA_4MS_CYC    ((`RSDIR_CLK_HZ / 1000) * 4)
`define RSDIR_TA_7MS_CYC    ((`RSDIR_CLK_HZ / 1000) * 7)
`define RSDIR_TA_14MS_CYC   ((`RSDIR_CLK_HZ / 1000) * 14)
`define RSDIR_TA_28MS_CYC   ((`RSDIR_CLK_HZ / 1000) * 28)
`define RSDIR_SW_38400      4'h0
`define RSDIR_SW_19200      4'h2
`define RSDIR_SW_9600       4'h4
`define RSDIR_SW_4800       4'h6
`define RSDIR_SW_2400       4'h8
`define RSDIR_SW_1200       4'ha
`define RSDIR_SW_600        4'hc
`define RSDIR_CNT_W         22
`define RSDIR_BUF_DEPTH     2
`endif

// file: rsdir_net_model.sv
// Behavioural RS-485 network controller seen from the converter
`timescale 1ns/1ps
`default_nettype none
// ******
// Network model
// ******
module rsdir_net_model (
   input  wire logic drv_en,
   input  wire logic drv_bit,
   input  wire logic send_en,
   input  wire logic send_bit,
   output var  logic line_rx
);
   // Line level: own echo while the converter drives, bias high when nobody drives
   always_comb begin
      if (drv_en) begin
         line_rx = drv_bit; // Reply held off while the converter drives
      end else if (send_en) begin
         line_rx = send_bit;
      end else begin
         line_rx = 1'b1; // Bias keeps an idle bus at mark
      end
   end
endmodule
`default_nettype wire

// file: rsdir_pkg.sv
// Types for the RS-232/RS-485 direction switch
package rsdir_pkg;
   typedef enum logic [1:0] {
      RSDIR_RX = 2'b01,
      RSDIR_TX = 2'b10
   } rsdir_mode_t;
endpackage

// file: rsdir_switch.sv
// Direction control and data path of the RS-232 to RS-485 converter
`timescale 1ns/1ps
`default_nettype none
`include "rsdir_consts.svh"

module rsdir_switch (
   input  wire logic              CORE_CLK,
   input  wire logic              RSTN,
   input  wire logic [3:0]        BAUD_SW,
   input  wire logic              RS232_TXD,
   output var  logic              RS232_RXD,
   input  wire logic              RS485_RX,
   output var  logic              RS485_TX,
   output var  logic              RS485_DE,
   output var  logic              MODE_TX,
   output var  logic              BAUD_BAD
);
   import rsdir_pkg::*;

   // ***************************************************************
   // Rate decode
   // ***************************************************************
   rsdir_mode_t                  mode;
   logic [`RSDIR_CNT_W-1:0]      ta_limit;
   logic                         sw_ok;
   logic                         txd_q;
   logic [`RSDIR_CNT_W-1:0]      idle_cnt;

   // Unlisted codes are rejected and hold the block in receive mode.
   // The switch is read every cycle, so moving it while transmitting takes
   // effect at once; the timer below tolerates a limit that shrinks under it.
   always_comb begin
      sw_ok    = 1'b1;
      ta_limit = `RSDIR_CNT_W'(`RSDIR_TA_1MS_CYC);
      case (BAUD_SW)
         `RSDIR_SW_38400: ta_limit = `RSDIR_CNT_W'(`RSDIR_TA_1MS_CYC);
         `RSDIR_SW_19200: ta_limit = `RSDIR_CNT_W'(`RSDIR_TA_1MS_CYC);
         `RSDIR_SW_9600:  ta_limit = `RSDIR_CNT_W'(`RSDIR_TA_2MS_CYC);
         `RSDIR_SW_4800:  ta_limit = `RSDIR_CNT_W'(`RSDIR_TA_4MS_CYC);
         `RSDIR_SW_2400:  ta_limit = `RSDIR_CNT_W'(`RSDIR_TA_7MS_CYC);
         `RSDIR_SW_1200:  ta_limit = `RSDIR_CNT_W'(`RSDIR_TA_14MS_CYC);
         `RSDIR_SW_600:   ta_limit = `RSDIR_CNT_W'(`RSDIR_TA_28MS_CYC);
         default:         sw_ok = 1'b0;
      endcase
   end

   // ***************************************************************
   // Activity detect and turnaround timer
   // ***************************************************************
   logic activity;
   assign activity = (RS232_TXD != txd_q);

   // Previous level of the transmit input; idle line is mark (high)
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         txd_q <= 1'b1;
      end else begin
         txd_q <= RS232_TXD;
      end
   end

   // Counts idle cycles; any edge restarts it so a slow character never trips it.
   // Stops at the limit rather than wrapping, so a lowered limit ends at once.
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         idle_cnt <= '0;
      end else if (mode != RSDIR_TX || activity || !RS232_TXD) begin
         idle_cnt <= '0;
      end else if (idle_cnt < ta_limit) begin
         idle_cnt <= idle_cnt + `RSDIR_CNT_W'(1);
      end
   end

   // ***************************************************************
   // Direction state machine
   // ***************************************************************
   logic ta_done;
   assign ta_done = (idle_cnt >= ta_limit);

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode <= RSDIR_RX;
      end else begin
         unique case (mode)
            RSDIR_RX: begin
               if (sw_ok && (activity || !RS232_TXD)) begin
                  mode <= RSDIR_TX;
               end
            end
            RSDIR_TX: begin
               if (ta_done || !sw_ok) begin
                  mode <= RSDIR_RX;
               end
            end
            default: mode <= RSDIR_RX;
         endcase
      end
   end

   // ***************************************************************
   // Two-entry bit buffer on the RS-232 to RS-485 path
   // ***************************************************************
   // Sink is always ready here, but the buffer keeps the line level
   // aligned with the direction change so the first start bit survives.
   // The older entry drives the pin: the path is three cycles deep, which
   // gives the driver enable one cycle of lead over the first data bit.
   logic [`RSDIR_BUF_DEPTH-1:0] buf_bit;
   logic [1:0]                  buf_cnt;
   logic                        in_valid;
   logic                        in_ready;
   logic                        out_valid;
   logic                        out_ready;
   assign in_valid  = 1'b1;
   assign in_ready  = (buf_cnt != 2'(`RSDIR_BUF_DEPTH)) || out_ready;
   assign out_valid = (buf_cnt != 2'h0);
   assign out_ready = 1'b1;

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         buf_bit <= '1;
         buf_cnt <= 2'h0;
      end else begin
         if (in_valid && in_ready) begin
            buf_bit <= {buf_bit[0], RS232_TXD};
         end
         if (in_valid && in_ready && !(out_valid && out_ready)) begin
            buf_cnt <= buf_cnt + 2'h1;
         end else if (!(in_valid && in_ready) && out_valid && out_ready) begin
            buf_cnt <= buf_cnt - 2'h1;
         end
      end
   end

   // ***************************************************************
   // Registered pin outputs
   // ***************************************************************
   // No RTS/CTS ports exist at all; only data lines are used
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         RS485_TX  <= 1'b1;
         RS485_DE  <= 1'b0;
         RS232_RXD <= 1'b1;
         MODE_TX   <= 1'b0;
         BAUD_BAD  <= 1'b0;
      end else begin
         RS485_DE  <= (mode == RSDIR_TX);
         RS485_TX  <= (out_valid) ? buf_bit[1] : 1'b1;
         RS232_RXD <= (mode == RSDIR_RX) ? RS485_RX : 1'b1;
         MODE_TX   <= (mode == RSDIR_TX);
         BAUD_BAD  <= !sw_ok;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sequence s_idle_run;
      (mode == RSDIR_TX && RS232_TXD && !activity) [*2];
   endsequence

   a_de_follows_mode: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      1'b1 |=> (RS485_DE == ($past(mode) == RSDIR_TX)))
      else $error("driver enable does not follow mode");

   a_rx_path_gated: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (mode == RSDIR_TX) |=> RS232_RXD)
      else $error("receive path open in transmit mode");

   a_start_enters_tx: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (mode == RSDIR_RX && sw_ok && !RS232_TXD) |=> (mode == RSDIR_TX))
      else $error("start bit did not enter transmit mode");

   a_edge_restarts: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (mode == RSDIR_TX && activity) |=> (idle_cnt == '0))
      else $error("edge did not restart timer");

   a_no_early_exit: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (mode == RSDIR_TX && sw_ok && !ta_done) |=> (mode == RSDIR_TX))
      else $error("left transmit before turnaround");

   a_timer_counts: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      s_idle_run |-> (idle_cnt == $past(idle_cnt) + `RSDIR_CNT_W'(1)) || ta_done)
      else $error("idle timer not counting");

   a_limit_38400: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (BAUD_SW == `RSDIR_SW_38400) |-> (ta_limit == `RSDIR_CNT_W'(125000)))
      else $error("wrong turnaround at 38400");

   a_limit_600: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (BAUD_SW == `RSDIR_SW_600) |-> (ta_limit == `RSDIR_CNT_W'(3500000)))
      else $error("wrong turnaround at 600");

   a_bad_code_rx: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (!sw_ok) |=> (mode == RSDIR_RX))
      else $error("illegal switch code left transmit active");

   a_data_forward: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      1'b1 |-> ##3 (RS485_TX == $past(RS232_TXD, 3)))
      else $error("transmit data not forwarded");

   // Start bit path: transmit mode on the next edge, driver one edge later
   sequence s_start_seen;
      (mode == RSDIR_RX) && sw_ok && !RS232_TXD;
   endsequence

   sequence s_driver_up;
      (mode == RSDIR_TX) ##1 (RS485_DE && MODE_TX);
   endsequence

   a_start_raises_de: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      s_start_seen |=> s_driver_up)
      else $error("start bit did not raise driver enable");

   // Turnaround path: receive mode on the next edge, driver off one edge later
   sequence s_turn_back;
      (mode == RSDIR_RX) ##1 (!RS485_DE && !MODE_TX);
   endsequence

   a_done_turns_back: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      ((mode == RSDIR_TX) && ta_done) |=> s_turn_back)
      else $error("turnaround end did not release driver");

   a_rxd_follows_net: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (mode == RSDIR_RX) |=> (RS232_RXD == $past(RS485_RX)))
      else $error("network data not passed to terminal");

   a_no_drive_rx: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (mode == RSDIR_RX) |=> !RS485_DE)
      else $error("driver enabled in receive mode");

   a_mode_copy: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      1'b1 |=> (MODE_TX == ($past(mode) == RSDIR_TX)))
      else $error("mode output does not follow mode");

   a_bad_flag: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      1'b1 |=> (BAUD_BAD == !$past(sw_ok)))
      else $error("bad code flag does not follow switch");

   a_mode_legal: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (mode == RSDIR_RX) || (mode == RSDIR_TX))
      else $error("mode left its legal codes");

   a_buf_bound: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      buf_cnt <= 2'(`RSDIR_BUF_DEPTH))
      else $error("bit buffer overfilled");

   a_timer_held_rx: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (mode == RSDIR_RX) |=> (idle_cnt == '0))
      else $error("idle timer running in receive mode");

   // Each legal code maps to a turnaround count; 38400 and 19200 share the 1 ms count
   a_limit_19200: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (BAUD_SW == `RSDIR_SW_19200) |-> (ta_limit == `RSDIR_CNT_W'(`RSDIR_TA_1MS_CYC)))
      else $error("wrong turnaround at 19200");

   a_limit_9600: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (BAUD_SW == `RSDIR_SW_9600) |-> (ta_limit == `RSDIR_CNT_W'(`RSDIR_TA_2MS_CYC)))
      else $error("wrong turnaround at 9600");

   a_limit_4800: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (BAUD_SW == `RSDIR_SW_4800) |-> (ta_limit == `RSDIR_CNT_W'(`RSDIR_TA_4MS_CYC)))
      else $error("wrong turnaround at 4800");

   a_limit_2400: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (BAUD_SW == `RSDIR_SW_2400) |-> (ta_limit == `RSDIR_CNT_W'(`RSDIR_TA_7MS_CYC)))
      else $error("wrong turnaround at 2400");

   a_limit_1200: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (BAUD_SW == `RSDIR_SW_1200) |-> (ta_limit == `RSDIR_CNT_W'(`RSDIR_TA_14MS_CYC)))
      else $error("wrong turnaround at 1200");
endmodule
`default_nettype wire

// file: test_rs232_rs485_direction_switch.sv
// Self-checking testbench for the RS-232/RS-485 direction switch
`timescale 1ns/1ps
`default_nettype none
// ******
// Bench
// ******
module test_rs232_rs485_direction_switch;
   logic       core_clk;
   logic       rstn;
   logic [3:0] baud_sw;
   logic       txd;
   logic       rxd;
   logic       net_rx;
   logic       net_tx;
   logic       net_de;
   logic       mode_tx;
   logic       baud_bad;
   logic       send_en;
   logic       send_bit;
   int         mismatches;
   int         checked;

   // Bench terminal is DTE: its output feeds the transmit input directly
   // The terminal has no RTS or DTR lines at all
   rsdir_switch i_rsdir_switch (.CORE_CLK(core_clk), .RSTN(rstn), .BAUD_SW(baud_sw),
      .RS232_TXD(txd), .RS232_RXD(rxd), .RS485_RX(net_rx), .RS485_TX(net_tx),
      .RS485_DE(net_de), .MODE_TX(mode_tx), .BAUD_BAD(baud_bad));
   rsdir_net_model i_rsdir_net_model (.drv_en(net_de), .drv_bit(net_tx),
      .send_en(send_en), .send_bit(send_bit), .line_rx(net_rx));

   // Single-bit comparison with case equality so unknowns never match
   task automatic check1(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask
   // Inputs only move at the falling edge
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic final_report();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ******
   // Scenarios
   // ******
   task automatic t_reset();
      check1("rxd", 1'b1, rxd);
      check1("tx", 1'b1, net_tx);
      check1("de", 1'b0, net_de);
      check1("mode", 1'b0, mode_tx);
      check1("bad", 1'b0, baud_bad);
      $display("test reset done");
   endtask
   // Network data reaches the terminal one cycle late
   task automatic t_rx_path();
      logic [7:0] pat;
      pat = 8'h9c;
      send_en = 1'b1;
      for (int i = 0; i < 9; i++) begin
         if (i > 0) check1("rxd", pat[i-1], rxd);
         check1("de", 1'b0, net_de);
         send_bit = (i < 8) ? pat[i] : 1'b1;
         cyc(1);
      end
      send_en = 1'b0;
      $display("test rx path done");
   endtask
   // Illegal codes keep the driver off but still pass data
   task automatic t_codes();
      for (int c = 0; c < 16; c++) begin
         baud_sw = 4'(c);
         cyc(3);
         check1("bad", 1'(c > 12 || c[0]), baud_bad);
      end
      txd = 1'b0;
      cyc(4);
      check1("de", 1'b0, net_de);
      check1("tx", 1'b0, net_tx);
      txd = 1'b1;
      cyc(4);
      baud_sw = 4'h0;
      cyc(2);
      $display("test codes done");
   endtask
   // A start bit flips to transmit at once; data lags three cycles
   task automatic t_tx();
      logic [10:0] pat;
      pat = 11'h5a6; // Eleven-bit character
      for (int i = 0; i < 14; i++) begin
         if (i == 2) check1("de", 1'b1, net_de);
         if (i == 2) check1("mode", 1'b1, mode_tx);
         if (i >= 3) check1("tx", pat[i-3], net_tx);
         if (i >= 3) check1("rxd", 1'b1, rxd);
         txd = (i < 11) ? pat[i] : 1'b1;
         cyc(1);
      end
      $display("test tx done");
   endtask
   // A late edge restarts the 1 ms idle count at 38400
   task automatic t_turn();
      cyc(10000);
      check1("de", 1'b1, net_de);
      txd = 1'b0;
      cyc(1);
      txd = 1'b1;
      cyc(124900);
      check1("de", 1'b1, net_de);
      cyc(120);
      check1("de", 1'b0, net_de);
      check1("mode", 1'b0, mode_tx);
      $display("test turnaround done");
   endtask

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Watchdog: the tests need about 135000 cycles
   initial begin
      repeat (200000) @(posedge core_clk);
      mismatches++;
      final_report();
   end
   initial begin
      rstn = 1'b0;
      baud_sw = 4'h0;
      txd = 1'b1;
      send_en = 1'b0;
      send_bit = 1'b1;
      mismatches = 0;
      checked = 0;
      cyc(5);
      t_reset();
      cyc(5);
      rstn = 1'b1;
      cyc(2);
      t_rx_path();
      t_codes();
      t_tx();
      t_turn();
      t_rx_path(); // Network replies only after the turnaround
      final_report();
   end
endmodule
`default_nettype wire
